// File: verilog/rtc_pkg.sv
package rtc_pkg;

   // register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W  = 32;

   // register offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ALARM  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_ROUTE  = 8'h14;

   // event bit positions in status, mask and route fields
   localparam int unsigned EV_ALARM = 0;
   localparam int unsigned EV_MISS  = 1;
   localparam int unsigned EV_W     = 2;

   // route register: wake enables low, reset enables above
   localparam int unsigned ROUTE_WAKE_LSB  = 0;
   localparam int unsigned ROUTE_RESET_LSB = 2;
   localparam int unsigned ROUTE_W         = 4;

   // sixteen load capacitance settings
   localparam int unsigned CAP_W = 4;

   typedef struct packed {
      logic [CAP_W-1:0] load_cap_config;
      logic             alarm_enable;
      logic             osc_pin_short_control;
      logic             run_enable;
      logic             lowfreq_osc_enable;
      logic             bias_double_select;
      logic             osc_mode_select;
   } ctrl_s;

   localparam int unsigned CTRL_W = $bits(ctrl_s);

   // reset values
   localparam ctrl_s             CTRL_RESET  = '0;
   localparam logic [CNT_W-1:0]  COUNT_RESET = 32'h00000000;
   localparam logic [CNT_W-1:0]  ALARM_RESET = 32'hFFFFFFFF;
   localparam logic [EV_W-1:0]   EV_NONE     = 2'h0;
   localparam logic [ROUTE_W-1:0] ROUTE_RESET = 4'h0;

   // counter step per tick: bit 0 for crystal or self-oscillate, bit 1 for internal oscillator
   localparam logic [CNT_W-1:0] STEP_OSC = 32'h00000001;
   localparam logic [CNT_W-1:0] STEP_LFO = 32'h00000002;

   // missing-oscillator timeout
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned MISS_TIME_US = 1000;
   localparam int unsigned MISS_CYCLES  = MISS_TIME_US * CLK_MHZ;

endpackage

// File: verilog/tick_sync.sv
`timescale 1ns/1ns
// brings a slow oscillator into the system clock and flags its rising edges
module tick_sync (
   input  wire logic CLK,
   input  wire logic RST,
   input  wire logic CE,
   input  wire logic OSC_IN,
   output logic      RISE
);
   logic meta;
   logic stable;
   logic prev;

   // two flops first; only the second one is looked at
   always_ff @(posedge CLK) begin
      if (RST) begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
      end else if (CE) begin
         meta   <= OSC_IN;
         stable <= meta;
         prev   <= stable;
      end
   end

   // one-cycle pulse per oscillator period
   always_ff @(posedge CLK) begin
      if (RST) begin
         RISE <= 1'b0;
      end else if (CE) begin
         RISE <= stable & ~prev;
      end
   end
endmodule // tick_sync

// File: verilog/rtc_timebase.sv
`timescale 1ns/1ns
// Notes on behaviour
// - free-running 32-bit counter with alarm, advanced by slow oscillator ticks only
// - four-bit load capacitance setting, sixteen levels, written by software
// - counting never depends on the power-down state of the rest of the chip
// - alarm and missing-oscillator events route to wake and reset outputs
// - full 32-bit count at 32.768 kHz spans about 36 hours before wrap
// - oscillator mode bit at 0 selects self-oscillate mode without crystal
// - bias double bit picks about 20 kHz at 0, about 40 kHz at 1
// - software switch shorts the two oscillator pins together
// - internal oscillator enable bit both enables and selects that oscillator
// - internal oscillator ticks add at bit 1, doubling the effective rate
// - self-oscillate and internal modes count from the first tick, no wait
module rtc_timebase #(
   parameter int unsigned MISS_LIMIT = rtc_pkg::MISS_CYCLES
) (
   input  wire logic                       CLK,
   input  wire logic                       RST,
   input  wire logic                       CE,
   input  wire logic [rtc_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [rtc_pkg::DATA_W-1:0] WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output logic      [rtc_pkg::DATA_W-1:0] RDATA,
   input  wire logic                       OSC_TICK,
   input  wire logic                       LFO_TICK,
   input  wire logic                       POWER_DOWN,
   output logic                            OSC_MODE_SELECT,
   output logic                            BIAS_DOUBLE_SELECT,
   output logic                            LOWFREQ_OSC_ENABLE,
   output logic                            OSC_PIN_SHORT_CONTROL,
   output logic      [rtc_pkg::CAP_W-1:0]  LOAD_CAP_CONFIG,
   output logic                            IRQ,
   output logic                            WAKE_REQ,
   output logic                            RESET_REQ
);

   localparam int unsigned MISS_W = $clog2(MISS_LIMIT + 1);
   localparam logic [MISS_W-1:0] MISS_LAST = MISS_W'(MISS_LIMIT - 1);
   localparam logic [MISS_W-1:0] MISS_SAT  = MISS_W'(MISS_LIMIT);
   localparam logic [MISS_W-1:0] MISS_ZERO = '0;

   rtc_pkg::ctrl_s                ctrl;
   logic [rtc_pkg::CNT_W-1:0]     count;
   logic [rtc_pkg::CNT_W-1:0]     alarm;
   logic [rtc_pkg::EV_W-1:0]      status;
   logic [rtc_pkg::EV_W-1:0]      mask;
   logic [rtc_pkg::ROUTE_W-1:0]   route;
   logic [MISS_W-1:0]             miss_cnt;
   logic                          osc_rise;
   logic                          lfo_rise;
   logic                          tick;
   logic [rtc_pkg::CNT_W-1:0]     step;
   logic [rtc_pkg::CNT_W-1:0]     next_count;
   logic                          advance;
   logic                          alarm_hit;
   logic                          miss_hit;
   logic [rtc_pkg::EV_W-1:0]      events;
   logic [rtc_pkg::EV_W-1:0]      next_status;
   logic                          wr_ctrl;
   logic                          wr_count;
   logic                          wr_alarm;
   logic                          wr_mask;
   logic                          wr_route;
   logic                          rd_status;
   logic                          pwr_meta;
   logic                          pwr_sync;
   rtc_pkg::ctrl_s                wdata_ctrl;
   logic                          first_wait;

   // the two oscillator inputs are asynchronous; each gets its own synchroniser
   tick_sync u_osc_sync (
      .CLK    (CLK),
      .RST    (RST),
      .CE     (CE),
      .OSC_IN (OSC_TICK),
      .RISE   (osc_rise)
   );

   tick_sync u_lfo_sync (
      .CLK    (CLK),
      .RST    (RST),
      .CE     (CE),
      .OSC_IN (LFO_TICK),
      .RISE   (lfo_rise)
   );

   // power-down level is only watched, never used to stop the counter
   always_ff @(posedge CLK) begin
      if (RST) begin
         pwr_meta <= 1'b0;
         pwr_sync <= 1'b0;
      end else if (CE) begin
         pwr_meta <= POWER_DOWN;
         pwr_sync <= pwr_meta;
      end
   end

   // address decode; strobes are single cycle so no access is ever held off
   assign wr_ctrl   = WR && (ADDR == rtc_pkg::OFS_CTRL);
   assign wr_count  = WR && (ADDR == rtc_pkg::OFS_COUNT);
   assign wr_alarm  = WR && (ADDR == rtc_pkg::OFS_ALARM);
   assign wr_mask   = WR && (ADDR == rtc_pkg::OFS_MASK);
   assign wr_route  = WR && (ADDR == rtc_pkg::OFS_ROUTE);
   assign rd_status = RD && (ADDR == rtc_pkg::OFS_STATUS);

   // write data seen through the control layout, shared by the register and its checks
   assign wdata_ctrl = rtc_pkg::ctrl_s'(WDATA[rtc_pkg::CTRL_W-1:0]);

   // control register; its fields drive the oscillator analog controls directly
   always_ff @(posedge CLK) begin
      if (RST) begin
         ctrl <= rtc_pkg::CTRL_RESET;
      end else if (CE && wr_ctrl) begin
         ctrl <= wdata_ctrl;
      end
   end

   assign OSC_MODE_SELECT       = ctrl.osc_mode_select;
   assign BIAS_DOUBLE_SELECT    = ctrl.bias_double_select;
   assign LOWFREQ_OSC_ENABLE    = ctrl.lowfreq_osc_enable;
   assign OSC_PIN_SHORT_CONTROL = ctrl.osc_pin_short_control;
   assign LOAD_CAP_CONFIG       = ctrl.load_cap_config;

   // source select: the internal oscillator enable also picks it as the tick source
   assign tick = ctrl.lowfreq_osc_enable ? lfo_rise : osc_rise;
   assign step = ctrl.lowfreq_osc_enable ? rtc_pkg::STEP_LFO : rtc_pkg::STEP_OSC;

   // no start-up qualification: the first tick after run counts at once
   assign advance    = ctrl.run_enable && tick;
   assign next_count = count + step;

   // a software write to the count wins over a tick in the same cycle
   always_ff @(posedge CLK) begin
      if (RST) begin
         count <= rtc_pkg::COUNT_RESET;
      end else if (CE) begin
         if (wr_count) begin
            count <= WDATA;
         end else if (advance) begin
            count <= next_count;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         alarm <= rtc_pkg::ALARM_RESET;
      end else if (CE && wr_alarm) begin
         alarm <= WDATA;
      end
   end

   // match on the value the count is about to take, so each match fires once
   assign alarm_hit = ctrl.alarm_enable && advance && !wr_count && (next_count == alarm);

   // cycles since the last tick; saturates so the event fires once per outage
   always_ff @(posedge CLK) begin
      if (RST) begin
         miss_cnt <= MISS_ZERO;
      end else if (CE) begin
         if (!ctrl.run_enable || tick) begin
            miss_cnt <= MISS_ZERO;
         end else if (miss_cnt != MISS_SAT) begin
            miss_cnt <= miss_cnt + 1'b1;
         end
      end
   end

   assign miss_hit = ctrl.run_enable && !tick && (miss_cnt == MISS_LAST);

   // sticky status; a new event beats the clear-on-read in the same cycle
   always_comb begin
      events                   = rtc_pkg::EV_NONE;
      events[rtc_pkg::EV_ALARM] = alarm_hit;
      events[rtc_pkg::EV_MISS]  = miss_hit;
      next_status              = (rd_status ? rtc_pkg::EV_NONE : status) | events;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         status <= rtc_pkg::EV_NONE;
      end else if (CE) begin
         status <= next_status;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         mask  <= rtc_pkg::EV_NONE;
         route <= rtc_pkg::ROUTE_RESET;
      end else if (CE) begin
         if (wr_mask) begin
            mask <= WDATA[rtc_pkg::EV_W-1:0];
         end
         if (wr_route) begin
            route <= WDATA[rtc_pkg::ROUTE_W-1:0];
         end
      end
   end

   // outputs from flops; they lag status by one cycle
   always_ff @(posedge CLK) begin
      if (RST) begin
         IRQ       <= 1'b0;
         WAKE_REQ  <= 1'b0;
         RESET_REQ <= 1'b0;
      end else if (CE) begin
         IRQ       <= |(status & mask);
         WAKE_REQ  <= |(status & route[rtc_pkg::ROUTE_WAKE_LSB +: rtc_pkg::EV_W]);
         RESET_REQ <= |(status & route[rtc_pkg::ROUTE_RESET_LSB +: rtc_pkg::EV_W]);
      end
   end

   // read data valid only in the cycle after the strobe; zero otherwise
   always_ff @(posedge CLK) begin
      if (RST) begin
         RDATA <= '0;
      end else if (CE) begin
         RDATA <= '0;
         if (RD) begin
            case (ADDR)
               rtc_pkg::OFS_CTRL: begin
                  RDATA <= rtc_pkg::DATA_W'(ctrl);
               end
               rtc_pkg::OFS_COUNT: begin
                  RDATA <= count;
               end
               rtc_pkg::OFS_ALARM: begin
                  RDATA <= alarm;
               end
               rtc_pkg::OFS_STATUS: begin
                  RDATA <= rtc_pkg::DATA_W'({pwr_sync, status});
               end
               rtc_pkg::OFS_MASK: begin
                  RDATA <= rtc_pkg::DATA_W'(mask);
               end
               rtc_pkg::OFS_ROUTE: begin
                  RDATA <= rtc_pkg::DATA_W'(route);
               end
               default: begin
                  RDATA <= '0;
               end
            endcase
         end
      end
   end

   // helper for the start-up check: high from run off until the first tick after run on
   always_ff @(posedge CLK) begin
      if (RST) begin
         first_wait <= 1'b1;
      end else if (CE) begin
         if (!ctrl.run_enable) begin
            first_wait <= 1'b1;
         end else if (tick) begin
            first_wait <= 1'b0;
         end
      end
   end

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_tick_osc;
      CE && advance && !wr_count && !ctrl.lowfreq_osc_enable;
   endsequence

   sequence s_tick_lfo;
      CE && advance && !wr_count && ctrl.lowfreq_osc_enable;
   endsequence

   sequence s_quiet_read;
      CE && rd_status && !alarm_hit && !miss_hit;
   endsequence

   a_osc_step_one: assert property (s_tick_osc |=> count == $past(count) + rtc_pkg::STEP_OSC)
      else $error("count did not step by one on oscillator tick");

   a_lfo_step_two: assert property (s_tick_lfo |=> count == $past(count) + rtc_pkg::STEP_LFO)
      else $error("count did not step by two on internal oscillator tick");

   a_count_holds: assert property (CE && !advance && !wr_count |=> $stable(count))
      else $error("count moved without a tick");

   a_powerdown_runs: assert property (CE && pwr_sync && advance && !wr_count |=> count != $past(count))
      else $error("count stopped during power-down");

   a_alarm_sets: assert property (CE && alarm_hit |=> status[rtc_pkg::EV_ALARM] && count == $past(alarm))
      else $error("alarm match did not set the flag");

   a_alarm_sticky: assert property (status[rtc_pkg::EV_ALARM] && !(CE && rd_status)
                                    |=> status[rtc_pkg::EV_ALARM])
      else $error("alarm flag dropped without a read");

   a_alarm_quiet: assert property (CE && !alarm_hit && !status[rtc_pkg::EV_ALARM]
                                   |=> !status[rtc_pkg::EV_ALARM])
      else $error("alarm flag set without a match");

   a_read_clears: assert property (s_quiet_read |=> status == rtc_pkg::EV_NONE)
      else $error("status not cleared by read");

   a_miss_sets: assert property (CE && miss_hit |=> status[rtc_pkg::EV_MISS])
      else $error("missing oscillator not flagged");

   a_miss_quiet: assert property (CE && !miss_hit && !status[rtc_pkg::EV_MISS]
                                  |=> !status[rtc_pkg::EV_MISS])
      else $error("missing oscillator flag set without a timeout");

   a_wake_route: assert property (CE && status[rtc_pkg::EV_ALARM] && route[rtc_pkg::ROUTE_WAKE_LSB]
                                  |=> WAKE_REQ)
      else $error("alarm not routed to wake");

   a_reset_route: assert property (CE && status[rtc_pkg::EV_MISS] && route[rtc_pkg::ROUTE_RESET_LSB + 1]
                                   |=> RESET_REQ)
      else $error("missing oscillator not routed to reset");

   a_irq_level: assert property (CE && |(status & mask) |=> IRQ)
      else $error("unmasked event did not raise the interrupt");

   a_irq_quiet: assert property (CE && !(|(status & mask)) |=> !IRQ)
      else $error("interrupt high with no unmasked event");

   a_no_startup_wait: assert property (CE && ctrl.run_enable && first_wait && tick && !wr_count
                                       |=> count != $past(count))
      else $error("first tick after run was not counted");

   a_cap_follows: assert property (CE && wr_ctrl |=> LOAD_CAP_CONFIG == $past(wdata_ctrl.load_cap_config))
      else $error("load capacitance did not follow write");

   a_mode_follows: assert property (CE && wr_ctrl |=> OSC_MODE_SELECT == $past(wdata_ctrl.osc_mode_select))
      else $error("oscillator mode did not follow write");

   a_bias_follows: assert property (CE && wr_ctrl
                                    |=> BIAS_DOUBLE_SELECT == $past(wdata_ctrl.bias_double_select))
      else $error("bias select did not follow write");

   a_short_follows: assert property (CE && wr_ctrl
                                     |=> OSC_PIN_SHORT_CONTROL == $past(wdata_ctrl.osc_pin_short_control))
      else $error("pin short switch did not follow write");

   a_lfo_follows: assert property (CE && wr_ctrl
                                   |=> LOWFREQ_OSC_ENABLE == $past(wdata_ctrl.lowfreq_osc_enable))
      else $error("internal oscillator enable did not follow write");

endmodule // rtc_timebase

// File: test/tb.sv
`timescale 1ns/1ns
module tb;
   localparam int unsigned MISS = 60; // short timeout keeps the missing-oscillator wait brief
   localparam int LIMIT = 20000;

   logic        CLK        = 1'b0;
   logic        RST        = 1'b1;
   logic        CE         = 1'b1;
   logic [7:0]  ADDR       = 8'h00;
   logic [31:0] WDATA      = 32'h00000000;
   logic        WR         = 1'b0;
   logic        RD         = 1'b0;
   logic [31:0] RDATA;
   logic        OSC_TICK   = 1'b0;
   logic        LFO_TICK   = 1'b0;
   logic        POWER_DOWN = 1'b0;
   logic        OSC_MODE_SELECT;
   logic        BIAS_DOUBLE_SELECT;
   logic        LOWFREQ_OSC_ENABLE;
   logic        OSC_PIN_SHORT_CONTROL;
   logic [3:0]  LOAD_CAP_CONFIG;
   logic        IRQ;
   logic        WAKE_REQ;
   logic        RESET_REQ;
   int          n_fail     = 0;
   int          n_checks   = 0;
   int          cycles     = 0;
   logic [31:0] r_cnt;
   // register model kept from the rules; read predictions wait in a queue
   int unsigned m_cnt      = 0;
   int unsigned m_alarm    = 32'hFFFFFFFF;
   int unsigned m_ctrl     = 0;
   int unsigned m_stat     = 0;
   int unsigned m_mask     = 0;
   int unsigned m_route    = 0;
   int unsigned rd_q[$];
   logic [9:0]  v;

   rtc_timebase #(.MISS_LIMIT(MISS)) u_dut (
      .CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .OSC_TICK(OSC_TICK), .LFO_TICK(LFO_TICK), .POWER_DOWN(POWER_DOWN),
      .OSC_MODE_SELECT(OSC_MODE_SELECT), .BIAS_DOUBLE_SELECT(BIAS_DOUBLE_SELECT),
      .LOWFREQ_OSC_ENABLE(LOWFREQ_OSC_ENABLE), .OSC_PIN_SHORT_CONTROL(OSC_PIN_SHORT_CONTROL),
      .LOAD_CAP_CONFIG(LOAD_CAP_CONFIG), .IRQ(IRQ), .WAKE_REQ(WAKE_REQ), .RESET_REQ(RESET_REQ)
   );

   // 100 MHz system clock
   initial begin
      forever #5 CLK = ~CLK;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // hang guard, well above the few hundred cycles the tests need
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         n_fail++;
         $display("Error at %0t: cycle limit reached", $time);
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK);
      WR    <= 1'b0;
      // the model takes a write only where the design does
      if (CE) begin
         case (a)
            8'h00: m_ctrl = d[9:0];
            8'h04: m_cnt = d;
            8'h08: m_alarm = d;
            8'h10: m_mask = d[1:0];
            8'h14: m_route = d[3:0];
            default: ;
         endcase
      end
   endtask

   // model view of a register read
   function automatic int unsigned m_read(input logic [7:0] a);
      case (a)
         8'h00: return m_ctrl;
         8'h04: return m_cnt;
         8'h08: return m_alarm;
         8'h0C: return m_stat | (POWER_DOWN ? 4 : 0);
         8'h10: return m_mask;
         8'h14: return m_route;
         default: return 0;
      endcase
   endfunction

   // read data stand only in the cycle after the strobe, so sample there
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge CLK);
      ADDR <= a;
      RD   <= 1'b1;
      rd_q.push_back(m_read(a));
      if (a == 8'h0C) m_stat = 0;
      @(posedge CLK);
      RD   <= 1'b0;
      #1;
      chk(RDATA, exp);
      chk(RDATA, rd_q.pop_front());
   endtask

   // whole oscillator periods, each level held well past the synchroniser
   task automatic tick(input int n, input bit internal_slow_oscillator);
      repeat (n) begin
         @(posedge CLK);
         if (internal_slow_oscillator) LFO_TICK <= 1'b1;
         else OSC_TICK <= 1'b1;
         repeat (3) @(posedge CLK);
         OSC_TICK <= 1'b0;
         LFO_TICK <= 1'b0;
         repeat (3) @(posedge CLK);
         // model: a tick counts only while running, by two from the internal oscillator
         if (CE && m_ctrl[3]) begin
            m_cnt += m_ctrl[2] ? 2 : 1;
            if (m_ctrl[5] && m_cnt == m_alarm) m_stat |= 1;
         end
      end
      repeat (4) @(posedge CLK);
   endtask

   task automatic outs(input logic [3:0] exp);
      #1;
      chk({29'h0, IRQ, WAKE_REQ, RESET_REQ}, {29'h0, exp[2:0]});
      chk({29'h0, IRQ, WAKE_REQ, RESET_REQ},
          {29'h0, |(m_stat & m_mask), |(m_stat & m_route & 3), |(m_stat & (m_route >> 2))});
   endtask

   initial begin
      void'($urandom(55041));
      repeat (5) @(posedge CLK);
      RST <= 1'b0;
      // reset state of every register, and an unmapped place
      rdchk(8'h00, 32'h00000000);
      rdchk(8'h04, 32'h00000000);
      rdchk(8'h08, 32'hFFFFFFFF);
      rdchk(8'h0C, 32'h00000000);
      rdchk(8'h10, 32'h00000000);
      rdchk(8'h14, 32'h00000000);
      wr(8'h3C, 32'hFFFFFFFF);
      rdchk(8'h3C, 32'h00000000);
      outs(4'h0);
      $display("test reset done");

      // all sixteen load settings with random mode bits; run and alarm kept off
      for (int i = 0; i < 16; i++) begin
         v = 10'($urandom() & 32'h00000017) | (10'(i) << 6);
         wr(8'h00, {22'h0, v});
         rdchk(8'h00, {22'h0, v});
         chk({24'h0, LOAD_CAP_CONFIG, OSC_PIN_SHORT_CONTROL, LOWFREQ_OSC_ENABLE, BIAS_DOUBLE_SELECT,
              OSC_MODE_SELECT}, {24'h0, v[9:6], v[4], v[2], v[1], v[0]});
      end
      $display("test control done");

      // crystal-side ticks step bit 0, also while the chip is powered down
      @(posedge CLK);
      POWER_DOWN <= 1'b1;
      r_cnt = $urandom();
      wr(8'h04, r_cnt);
      wr(8'h00, 32'h00000008);
      tick(3, 1'b0);
      rdchk(8'h04, r_cnt + 32'h3);
      rdchk(8'h0C, 32'h00000004);
      @(posedge CLK);
      POWER_DOWN <= 1'b0;
      wr(8'h04, 32'hFFFFFFFE);
      tick(3, 1'b0);
      rdchk(8'h04, 32'h00000001);
      // internal oscillator steps bit 1
      wr(8'h00, 32'h0000000C);
      tick(2, 1'b1);
      rdchk(8'h04, 32'h00000005);
      // stopped counter ignores ticks
      wr(8'h00, 32'h00000000);
      tick(1, 1'b0);
      rdchk(8'h04, 32'h00000005);
      // clock enable low freezes everything: the write and the tick below are both lost
      wr(8'h00, 32'h00000008);
      @(posedge CLK);
      CE <= 1'b0;
      wr(8'h04, 32'h00000000);
      tick(1, 1'b0);
      @(posedge CLK);
      CE <= 1'b1;
      rdchk(8'h04, 32'h00000005);
      wr(8'h00, 32'h00000000);
      $display("test count done");

      // alarm reached by a tick, masked in and routed to wake
      wr(8'h04, 32'h00000010);
      wr(8'h08, 32'h00000013);
      wr(8'h10, 32'h00000001);
      wr(8'h14, 32'h00000001);
      wr(8'h00, 32'h00000028);
      tick(2, 1'b0);
      outs(4'h0);
      tick(1, 1'b0);
      outs(4'h6);
      rdchk(8'h0C, 32'h00000001);
      repeat (2) @(posedge CLK);
      outs(4'h0);
      rdchk(8'h0C, 32'h00000000);
      // masked out: flag still set, no interrupt
      wr(8'h10, 32'h00000000);
      wr(8'h04, 32'h00000012);
      tick(1, 1'b0);
      outs(4'h2);
      rdchk(8'h0C, 32'h00000001);
      wr(8'h00, 32'h00000000);
      $display("test alarm done");

      // silent oscillator while running raises the missing event, routed to reset
      wr(8'h10, 32'h00000002);
      wr(8'h14, 32'h00000008);
      wr(8'h00, 32'h00000008);
      repeat (MISS + 20) @(posedge CLK);
      if (m_ctrl[3]) m_stat |= 2; // silent past the limit while running
      outs(4'h5);
      rdchk(8'h0C, 32'h00000002);
      wr(8'h00, 32'h00000000);
      repeat (2) @(posedge CLK);
      outs(4'h0);
      $display("test missing done");
      conclude();
   end
endmodule // tb
